// >>> src/pmc_cfg.svh
// Purpose: Offsets, field positions, instruction and watchdog keys, and timing counts of the power-mode block
// Assumes: 10 MHz pclk, one state time per pclk cycle
// Notes:   Definitions only
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Register byte offsets on APB
`define PMC_OFS_CMD      8'h00
`define PMC_OFS_CFG0     8'h04
`define PMC_OFS_STATUS   8'h08
`define PMC_OFS_ENABLE   8'h0c
`define PMC_OFS_PEND     8'h10
`define PMC_OFS_WDOG     8'h14

// Field positions
`define PMC_CFG0_PD_BIT  0
`define PMC_EN_EXT_BIT   0
`define PMC_EN_WD_BIT    1
`define PMC_PEND_EXT_BIT 0

// Power-mode instruction keys
`define PMC_KEY_IDLE     8'h01
`define PMC_KEY_PD       8'h02

// Watchdog clear sequence
`define PMC_WD_KEY1      8'h1e
`define PMC_WD_KEY2      8'he1

// Timing: clock period, state time, reset pulse and watchdog span
`define PMC_CLK_NS       100
`define PMC_STATE_NS     100
`define PMC_RST_STATES   16
`define PMC_RST_CYCLES   ((`PMC_RST_STATES * `PMC_STATE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_WDOG_STATES  65536
`define PMC_WDOG_CYCLES  (`PMC_WDOG_STATES * `PMC_STATE_NS / `PMC_CLK_NS)
`define PMC_WAKE_MIN_NS  50

`endif

// >>> src/pmc_pkg.sv
// Purpose: Types shared by the power-mode block
// Assumes: Constants live in pmc_cfg.svh
// Notes:   Gray codes along run, idle, powerdown, oscillator wait
package pmc_pkg;

	typedef enum logic [2:0] {
		ST_RUN    = 3'h0,
		ST_IDLE   = 3'h1,
		ST_PD     = 3'h3,
		ST_PD_OSC = 3'h2,
		ST_RSTSEQ = 3'h6
	} pm_state_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic osc_en;
		logic clock_output_pin_high;
	} clk_ctrl_t;

	typedef struct packed {
		logic bus_ctrl_idle;
		logic vpp_pulldown;
		logic weak_pull_all;
	} pin_ctrl_t;

endpackage : pmc_pkg

// >>> src/pmc_sync2.sv
// Purpose: Two-flop level synchroniser into pclk
// Assumes: First stage is read only by the second
// Notes:   Frozen while ce is low
`timescale 1ns/1ps
module pmc_sync2 (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// Two stages; metastability settles in the first
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end
		else if (ce)
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : pmc_sync2

// >>> src/pmc_wake_catch.sv
// Purpose: Clockless wake catcher, toggles on a pin edge while armed
// Assumes: Pin edge clocks the flop; pclk may be stopped
// Notes:   Toggle is crossed into pclk by a synchroniser
`timescale 1ns/1ps
module pmc_wake_catch (
	input  wire logic wake_edge,
	input  wire logic rst_n,
	input  wire logic arm,
	output logic      tgl
);
	// Pulses shorter than a pclk period are still caught
	always_ff @(posedge wake_edge or negedge rst_n)
	begin
		if (!rst_n)
			tgl <= 1'b0;
		else if (arm)
			tgl <= ~tgl;
	end
endmodule : pmc_wake_catch

// >>> src/power_mode_controller.sv
// Purpose: Idle, powerdown, isolation and test-mode sequencing with APB registers
// Assumes: pclk is the state clock; presetn is the device reset pin
// Notes:   Clock gates are outputs; the clocks themselves live outside
//
// What this block does
// - Idle holds CPU clocks low; peripheral clocks and clock output run.
// - Power-mode instruction with operand 1 enters idle.
// - Any enabled interrupt or hardware reset leaves idle.
// - Interrupt wake from idle restarts CPU clocks and requests service.
// - Enabled watchdog counts in idle and resets after 64K state times.
// - Powerdown stops oscillator and all internal clocks.
// - Powerdown drives bus-control outputs inactive.
// - Powerdown drives clock output pin steadily high.
// - Config register bit 0 permits powerdown; cleared means powerdown disabled.
// - A device reset (presetn) loads config register 0 from config byte 0.
// - Power-mode instruction with operand 2 enters powerdown.
// - Watchdog resets the device in powerdown only if its count reaches the end on the entry edge.
// - Programming-voltage pin low wakes powerdown, clocks on, oscillator off.
// - External interrupt level wakes powerdown if pin is special-function.
// - External wake sets pending bit; enabled interrupt is serviced first.
// - Masked external wake resumes directly; pending stays until cleared.
// - External wake enables oscillator and pull-down, resumes below threshold.
// - Isolation-select low at reset release enters isolation mode.
// - Isolation weakly pulls all pins; only a device reset can end it.
// - Reset with isolation-select high leaves isolation on release.
// - Test-entry pin as input, low at reset release, enters test mode.
// - Any other operand to the power-mode instruction runs a reset sequence.
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module power_mode_controller #(
	parameter int unsigned WDOG_LIMIT = `PMC_WDOG_CYCLES
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [7:0]          chip_config_byte0,
	input  wire logic                irq_pending_any,
	input  wire logic                external_wake_interrupt,
	input  wire logic                program_voltage_pin,
	input  wire logic                vpp_below_thresh,
	input  wire logic                external_wake_interrupt_special_fn,
	input  wire logic                isolation_sel_n,
	input  wire logic                test_entry_n,
	input  wire logic                test_entry_is_input,
	output pmc_pkg::clk_ctrl_t       clk_ctrl,
	output pmc_pkg::pin_ctrl_t       pin_ctrl,
	output logic                     reset_req,
	output logic                     service_req,
	output logic                     isolation_mode,
	output logic                     test_mode
);
	localparam logic [16:0] WD_LAST  = 17'(WDOG_LIMIT - 1);
	localparam logic [4:0]  RST_LAST = 5'(`PMC_RST_CYCLES - 1);

	pmc_pkg::pm_state_t state_q, state_d;
	logic [16:0] wd_cnt_q, wd_cnt_d;
	logic [4:0]  rst_cnt_q, rst_cnt_d;
	logic [7:0]  cfg0_q, cfg0_d;
	logic        strap_done_q, strap_done_d;
	logic        iso_q, iso_d;
	logic        test_q, test_d;
	logic        ext_en_q, ext_en_d;
	logic        wd_act_q, wd_act_d;
	logic        wd_key1_q, wd_key1_d;
	logic        pend_q, pend_d;
	logic        osc_q, osc_d;
	logic        svc_q, svc_d;
	logic        svc_due_q, svc_due_d;
	logic        arm_q, arm_d;
	logic        ext_prev_q, ext_prev_d;
	logic        xt_prev_q, xt_prev_d;
	logic        vt_prev_q, vt_prev_d;
	logic [31:0] rdata_q, rdata_d;
	logic        err_q, err_d;

	logic ext_lvl, vpp_lvl, xt_tgl, vt_tgl, xt_tgl_s, vt_tgl_s;
	logic apb_wr, cmd_wr, wd_wr, mapped, ext_rise, ext_wake, vpp_wake, wd_over;

	// Clockless catchers for the two powerdown wake pins
	pmc_wake_catch u_ext_catch (
		.wake_edge (external_wake_interrupt),
		.rst_n     (presetn),
		.arm       (arm_q),
		.tgl       (xt_tgl)
	);
	pmc_wake_catch u_vpp_catch (
		.wake_edge (~program_voltage_pin),
		.rst_n     (presetn),
		.arm       (arm_q),
		.tgl       (vt_tgl)
	);

	// Cross toggles and pin levels into pclk
	pmc_sync2 u_sync_xt (.clk(pclk), .rst_n(presetn), .ce(ce), .d(xt_tgl), .q(xt_tgl_s));
	pmc_sync2 u_sync_vt (.clk(pclk), .rst_n(presetn), .ce(ce), .d(vt_tgl), .q(vt_tgl_s));
	pmc_sync2 u_sync_xl (.clk(pclk), .rst_n(presetn), .ce(ce),
		.d(external_wake_interrupt), .q(ext_lvl));
	pmc_sync2 u_sync_vl (.clk(pclk), .rst_n(presetn), .ce(ce),
		.d(~program_voltage_pin), .q(vpp_lvl));

	// Bus strobes and wake events
	assign pready   = ce;
	assign apb_wr   = psel & penable & pwrite & ce;
	assign cmd_wr   = apb_wr & (paddr == `PMC_OFS_CMD);
	assign wd_wr    = apb_wr & (paddr == `PMC_OFS_WDOG);
	assign ext_rise = ext_lvl & ~ext_prev_q;
	assign ext_wake = ((xt_tgl_s ^ xt_prev_q) | ext_lvl) & external_wake_interrupt_special_fn;
	assign vpp_wake = (vt_tgl_s ^ vt_prev_q) | vpp_lvl;
	assign wd_over  = wd_act_q & (wd_cnt_q == WD_LAST);
	assign mapped   = (paddr == `PMC_OFS_CMD) | (paddr == `PMC_OFS_CFG0) |
	                  (paddr == `PMC_OFS_STATUS) | (paddr == `PMC_OFS_ENABLE) |
	                  (paddr == `PMC_OFS_PEND) | (paddr == `PMC_OFS_WDOG);

	// Straps, configuration and mode sequencing
	always_comb
	begin
		strap_done_d = 1'b1;
		cfg0_d       = cfg0_q;
		iso_d        = iso_q;
		test_d       = test_q;
		ext_en_d     = ext_en_q;
		wd_act_d     = wd_act_q;
		wd_key1_d    = wd_key1_q;
		pend_d       = pend_q;
		osc_d        = osc_q;
		svc_d        = 1'b0;
		svc_due_d    = svc_due_q;
		state_d      = state_q;
		wd_cnt_d     = wd_cnt_q;
		rst_cnt_d    = rst_cnt_q;
		ext_prev_d   = ext_lvl;
		xt_prev_d    = xt_tgl_s;
		vt_prev_d    = vt_tgl_s;
		// Straps sampled once, on the first edge after reset release
		if (!strap_done_q)
		begin
			cfg0_d = chip_config_byte0;
			iso_d  = ~isolation_sel_n;
			test_d = test_entry_is_input & ~test_entry_n;
		end
		// Software writes
		if (apb_wr && paddr == `PMC_OFS_CFG0)
			cfg0_d = pwdata[7:0];
		if (apb_wr && paddr == `PMC_OFS_ENABLE)
		begin
			ext_en_d = pwdata[`PMC_EN_EXT_BIT];
			// Once active only a reset stops the watchdog
			wd_act_d = wd_act_q | pwdata[`PMC_EN_WD_BIT];
		end
		if (apb_wr && paddr == `PMC_OFS_PEND && pwdata[`PMC_PEND_EXT_BIT])
			pend_d = 1'b0;
		// Count runs through bus writes too; it counts only in run and idle, so powerdown freezes it
		if (wd_act_q && (state_q == pmc_pkg::ST_RUN || state_q == pmc_pkg::ST_IDLE))
			wd_cnt_d = wd_cnt_q + 17'h00001;
		// Two consecutive key writes clear the watchdog; the clear beats the count
		if (wd_wr)
		begin
			wd_key1_d = (pwdata[7:0] == `PMC_WD_KEY1);
			if (wd_key1_q && pwdata[7:0] == `PMC_WD_KEY2)
			begin
				wd_cnt_d = '0;
				wd_act_d = 1'b1;
			end
		end
		else if (apb_wr)
			wd_key1_d = 1'b0;
		// Normal-mode rising edge sets pending; set beats clear
		if (ext_rise && state_q != pmc_pkg::ST_PD)
			pend_d = 1'b1;
		unique case (state_q)
			pmc_pkg::ST_RUN:
			begin
				if (cmd_wr)
				begin
					if (pwdata[7:0] == `PMC_KEY_IDLE)
						state_d = pmc_pkg::ST_IDLE;
					else if (pwdata[7:0] == `PMC_KEY_PD)
					begin
						if (cfg0_q[`PMC_CFG0_PD_BIT])
						begin
							state_d = pmc_pkg::ST_PD;
							osc_d   = 1'b0;
						end
					end
					else
					begin
						state_d   = pmc_pkg::ST_RSTSEQ;
						rst_cnt_d = '0;
					end
				end
				if (svc_due_q)
				begin
					svc_d     = 1'b1;
					svc_due_d = 1'b0;
				end
			end
			pmc_pkg::ST_IDLE:
			begin
				// Only enabled sources reach irq_pending_any
				if (irq_pending_any || (ext_rise && ext_en_q))
				begin
					state_d = pmc_pkg::ST_RUN;
					svc_d   = 1'b1;
				end
			end
			pmc_pkg::ST_PD:
			begin
				if (ext_wake)
				begin
					state_d   = pmc_pkg::ST_PD_OSC;
					osc_d     = 1'b1;
					pend_d    = 1'b1;
					svc_due_d = ext_en_q;
				end
				else if (vpp_wake)
					state_d = pmc_pkg::ST_RUN;
			end
			pmc_pkg::ST_PD_OSC:
			begin
				// Clocks stay off until the pin discharges
				if (vpp_below_thresh)
					state_d = pmc_pkg::ST_RUN;
			end
			pmc_pkg::ST_RSTSEQ:
			begin
				rst_cnt_d = rst_cnt_q + 5'h01;
				if (rst_cnt_q == RST_LAST)
					state_d = pmc_pkg::ST_RUN;
			end
			default:
				state_d = pmc_pkg::ST_RSTSEQ;
		endcase
		// Overflow in any state but the reset sequence forces the reset pulse
		if (wd_over && state_q != pmc_pkg::ST_RSTSEQ)
		begin
			state_d   = pmc_pkg::ST_RSTSEQ;
			rst_cnt_d = '0;
			wd_cnt_d  = '0;
		end
	end

	// Catchers armed only while parked in powerdown
	assign arm_d = (state_d == pmc_pkg::ST_PD);

	// Register the mode state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q      <= pmc_pkg::ST_RUN;
			wd_cnt_q     <= '0;
			rst_cnt_q    <= '0;
			cfg0_q       <= 8'h00;
			strap_done_q <= 1'b0;
			iso_q        <= 1'b0;
			test_q       <= 1'b0;
			ext_en_q     <= 1'b0;
			wd_act_q     <= 1'b0;
			wd_key1_q    <= 1'b0;
			pend_q       <= 1'b0;
			osc_q        <= 1'b1;
			svc_q        <= 1'b0;
			svc_due_q    <= 1'b0;
			arm_q        <= 1'b0;
			ext_prev_q   <= 1'b0;
			xt_prev_q    <= 1'b0;
			vt_prev_q    <= 1'b0;
		end
		else if (ce)
		begin
			state_q      <= state_d;
			wd_cnt_q     <= wd_cnt_d;
			rst_cnt_q    <= rst_cnt_d;
			cfg0_q       <= cfg0_d;
			strap_done_q <= strap_done_d;
			iso_q        <= iso_d;
			test_q       <= test_d;
			ext_en_q     <= ext_en_d;
			wd_act_q     <= wd_act_d;
			wd_key1_q    <= wd_key1_d;
			pend_q       <= pend_d;
			osc_q        <= osc_d;
			svc_q        <= svc_d;
			svc_due_q    <= svc_due_d;
			arm_q        <= arm_d;
			ext_prev_q   <= ext_prev_d;
			xt_prev_q    <= xt_prev_d;
			vt_prev_q    <= vt_prev_d;
		end
	end

	// Read data captured in the setup phase, so the access phase has no wait
	always_comb
	begin
		rdata_d = rdata_q;
		err_d   = err_q;
		if (psel && !penable)
		begin
			err_d = ~mapped;
			unique case (paddr)
				`PMC_OFS_CFG0:   rdata_d = {24'h000000, cfg0_q};
				`PMC_OFS_STATUS: rdata_d = {24'h000000, osc_q, wd_act_q, test_q, iso_q,
				                            pend_q, state_q};
				`PMC_OFS_ENABLE: rdata_d = {30'h00000000, wd_act_q, ext_en_q};
				`PMC_OFS_PEND:   rdata_d = {31'h00000000, pend_q};
				default:         rdata_d = 32'h00000000;
			endcase
		end
	end

	// Register the bus answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q <= 32'h00000000;
			err_q   <= 1'b0;
		end
		else if (ce)
		begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// Outputs decoded from the mode register and the other registered flags
	assign prdata                 = rdata_q;
	assign pslverr                = err_q & psel & penable;
	assign clk_ctrl.cpu_clk_en    = (state_q == pmc_pkg::ST_RUN) |
	                                (state_q == pmc_pkg::ST_RSTSEQ);
	assign clk_ctrl.periph_clk_en = (state_q != pmc_pkg::ST_PD) &
	                                (state_q != pmc_pkg::ST_PD_OSC);
	assign clk_ctrl.osc_en        = osc_q;
	assign clk_ctrl.clock_output_pin_high   = (state_q == pmc_pkg::ST_PD) |
	                                (state_q == pmc_pkg::ST_PD_OSC);
	assign pin_ctrl.bus_ctrl_idle = clk_ctrl.clock_output_pin_high;
	assign pin_ctrl.vpp_pulldown  = (state_q == pmc_pkg::ST_PD_OSC);
	assign pin_ctrl.weak_pull_all = iso_q;
	assign reset_req              = (state_q == pmc_pkg::ST_RSTSEQ);
	assign service_req            = svc_q;
	assign isolation_mode         = iso_q;
	assign test_mode              = test_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_bad_key;
		ce && cmd_wr && state_q == pmc_pkg::ST_RUN && !wd_over &&
		pwdata[7:0] != `PMC_KEY_IDLE && pwdata[7:0] != `PMC_KEY_PD;
	endsequence
	sequence s_reset_pulse;
		reset_req [*8] ##1 reset_req [*8] ##1 !reset_req;
	endsequence
	sequence s_ext_pd_wake;
		ce && state_q == pmc_pkg::ST_PD && ext_wake;
	endsequence

	AST_IDLE_CLOCKS: assert property (state_q == pmc_pkg::ST_IDLE |->
		!clk_ctrl.cpu_clk_en && clk_ctrl.periph_clk_en && !clk_ctrl.clock_output_pin_high)
		else $error("idle clock gating wrong");
	AST_IDLE_ENTRY: assert property (ce && cmd_wr && state_q == pmc_pkg::ST_RUN && !wd_over &&
		pwdata[7:0] == `PMC_KEY_IDLE |=> state_q == pmc_pkg::ST_IDLE)
		else $error("idle key did not enter idle");
	AST_IDLE_WAKE: assert property (ce && state_q == pmc_pkg::ST_IDLE && irq_pending_any &&
		!wd_over |=> state_q == pmc_pkg::ST_RUN && service_req && clk_ctrl.cpu_clk_en)
		else $error("interrupt did not wake idle");
	AST_PD_OUTPUTS: assert property (state_q == pmc_pkg::ST_PD |-> !clk_ctrl.cpu_clk_en &&
		!clk_ctrl.periph_clk_en && !clk_ctrl.osc_en && clk_ctrl.clock_output_pin_high &&
		pin_ctrl.bus_ctrl_idle)
		else $error("powerdown outputs wrong");
	AST_PD_GATE: assert property (ce && cmd_wr && state_q == pmc_pkg::ST_RUN &&
		pwdata[7:0] == `PMC_KEY_PD |=> (state_q == pmc_pkg::ST_PD) == $past(cfg0_q[0]) ||
		state_q == pmc_pkg::ST_RSTSEQ)
		else $error("powerdown permit not honoured");
	AST_BAD_KEY: assert property (s_bad_key |=> s_reset_pulse)
		else $error("illegal key reset pulse wrong");
	AST_WD_FROZEN: assert property (state_q == pmc_pkg::ST_PD && $past(state_q) ==
		pmc_pkg::ST_PD |-> $stable(wd_cnt_q) && !reset_req)
		else $error("watchdog moved in powerdown");
	AST_EXT_WAKE: assert property (s_ext_pd_wake |=> state_q == pmc_pkg::ST_PD_OSC &&
		pend_q && clk_ctrl.osc_en && pin_ctrl.vpp_pulldown && !clk_ctrl.cpu_clk_en)
		else $error("external wake sequence wrong");
	AST_OSC_RESUME: assert property (ce && state_q == pmc_pkg::ST_PD_OSC && vpp_below_thresh
		&& !wd_over |=> state_q == pmc_pkg::ST_RUN ##1 service_req == $past(svc_due_q, 2) || !ce)
		else $error("resume after threshold wrong");
	AST_ISO_PULL: assert property (strap_done_q |=> $stable(isolation_mode) &&
		pin_ctrl.weak_pull_all == isolation_mode)
		else $error("isolation pulls missing");

endmodule : power_mode_controller

// >>> tb/pmc_far_side.sv
// Purpose: Board side of the power-mode block: wake pin, RC network, isolation strap
// Assumes: External clock keeps pclk running in powerdown
// Notes:   Programming-voltage pin reads low while driven low or discharged
`timescale 1ns/1ps
module pmc_far_side #(
	parameter int unsigned DISCHARGE = 20
) (
	input  wire logic pclk,
	input  wire logic vpp_pulldown,
	input  wire logic vpp_low_req,
	input  wire logic iso_req,
	output logic      program_voltage_pin,
	output logic      vpp_below_thresh,
	output logic      isolation_sel_n
);
	int unsigned charge_q;

	// Capacitor drains while the weak pull-down is on, recharges fast when released
	always_ff @(posedge pclk)
	begin
		if (!vpp_pulldown)
			charge_q <= 0;
		else if (charge_q < DISCHARGE)
			charge_q <= charge_q + 1;
	end

	// Threshold crossing and pin level; strap floats high when not requested
	assign vpp_below_thresh    = (charge_q >= DISCHARGE);
	assign program_voltage_pin = ~(vpp_low_req | vpp_below_thresh);
	assign isolation_sel_n     = ~iso_req;
endmodule : pmc_far_side

// >>> tb/power_mode_controller_bench.sv
// Purpose: Self-checking bench for the power-mode block over APB
// Assumes: ce tied high, so every APB access ends in its first access cycle
// Notes:   Short watchdog span keeps the run brief
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module power_mode_controller_bench;
	typedef struct packed {
		logic [31:0] data;
		logic [31:0] mask;
		logic        err;
	} note_t;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]         paddr, ccb;
	logic [31:0]        pwdata, prdata;
	logic               irq_any, ext_int, vpp_low, iso_req, vpp_pin, vpp_below, iso_n;
	logic               ext_sf, test_n, test_in, reset_req, service_req, iso_mode, test_mode;
	pmc_pkg::clk_ctrl_t clk_ctrl;
	pmc_pkg::pin_ctrl_t pin_ctrl;
	note_t              notes[$];
	note_t              n;
	int                 err_total, compares, svc_cnt, rst_run, rst_len, k, s;

	power_mode_controller #(.WDOG_LIMIT(64)) power_mode_controller_inst (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_config_byte0(ccb), .irq_pending_any(irq_any),
		.external_wake_interrupt(ext_int), .program_voltage_pin(vpp_pin),
		.vpp_below_thresh(vpp_below), .external_wake_interrupt_special_fn(ext_sf), .isolation_sel_n(iso_n),
		.test_entry_n(test_n), .test_entry_is_input(test_in), .clk_ctrl(clk_ctrl),
		.pin_ctrl(pin_ctrl), .reset_req(reset_req), .service_req(service_req),
		.isolation_mode(iso_mode), .test_mode(test_mode));

	pmc_far_side pmc_far_side_inst (
		.pclk(pclk), .vpp_pulldown(pin_ctrl.vpp_pulldown), .vpp_low_req(vpp_low),
		.iso_req(iso_req), .program_voltage_pin(vpp_pin), .vpp_below_thresh(vpp_below),
		.isolation_sel_n(iso_n));

	// Free-running 10 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp

	task automatic close_out;
		$display("Compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// Result watcher: each completed transfer consumes the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && pready)
		begin
			if (notes.size() == 0)
				cmp("note_queue", 32'h1, 32'h0);
			else
			begin
				n = notes.pop_front();
				cmp("pslverr", {31'h0, n.err}, {31'h0, pslverr});
				if (!pwrite)
					cmp("prdata", n.data & n.mask, prdata & n.mask);
			end
		end
		svc_cnt += (service_req === 1'b1);
		if (reset_req === 1'b1)
			rst_run++;
		else if (rst_run != 0)
		begin
			rst_len = rst_run;
			rst_run = 0;
		end
	end

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		int i;
		notes.push_back('{d, m, e});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			close_out_err("pready");
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic close_out_err(input string what);
		cmp(what, 32'h1, 32'h0);
		close_out;
	endtask : close_out_err

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		apb(1'b0, a, d, m, 1'b0);
	endtask : rd

	// Bounded wait: sel 0 for CPU clocks running, 1 for reset request
	task automatic wait_on(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			@(posedge pclk);
			if ((sel == 0 ? clk_ctrl.cpu_clk_en : reset_req) === 1'b1)
				return;
		end
		close_out_err(sel == 0 ? "cpu_clk_en" : "reset_req");
	endtask : wait_on

	task automatic do_reset(input int cyc);
		presetn <= 1'b0;
		repeat (cyc) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask : do_reset

	task automatic pins(input logic [6:0] exp);
		@(negedge pclk);
		cmp("pin_levels", {25'h0, exp}, {25'h0, clk_ctrl, pin_ctrl});
		// Back on the rising edge so the next stimulus launches there
		@(posedge pclk);
	endtask : pins

	task automatic vpp_wake;
		vpp_low <= 1'b1;
		repeat (2) @(posedge pclk);
		vpp_low <= 1'b0;
		wait_on(0, 20);
	endtask : vpp_wake

	// Hang guard
	initial
	begin
		repeat (60000) @(posedge pclk);
		close_out_err("run_time");
	end

	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{irq_any, ext_int, vpp_low, test_n, err_total, compares, svc_cnt, rst_run} = '0;
		{iso_req, test_in, ext_sf} = 3'h7;
		k = $urandom(32'h8b4990e3);
		ccb = 8'($urandom) | 8'h01;
		do_reset(8);
		cmp("modes", 32'h3, {30'h0, iso_mode, test_mode});
		pins(7'h71);
		rd(`PMC_OFS_CFG0, {24'h0, ccb}, 32'hff);
		rd(`PMC_OFS_STATUS, 32'h30, 32'h37);
		iso_req <= 1'b0;
		test_in <= 1'b0;
		ccb     <= 8'($urandom) & 8'hfe;
		do_reset(2);
		cmp("modes", 32'h0, {30'h0, iso_mode, test_mode});
		rd(`PMC_OFS_CFG0, {24'h0, ccb}, 32'hff);
		apb(1'b0, 8'h40, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 8'h44, 32'h5, 32'h0, 1'b1);
		wr(`PMC_OFS_CMD, 32'h2);
		rd(`PMC_OFS_STATUS, 32'h0, 32'h7);
		wr(`PMC_OFS_CMD, 32'h1);
		rd(`PMC_OFS_STATUS, 32'h1, 32'h7);
		pins(7'h30);
		s = svc_cnt;
		irq_any <= 1'b1;
		wait_on(0, 10);
		irq_any <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp("service_count", 32'h1, 32'(svc_cnt - s));
		wr(`PMC_OFS_CFG0, 32'h1);
		wr(`PMC_OFS_CMD, 32'h2);
		rd(`PMC_OFS_STATUS, 32'h3, 32'h7);
		pins(7'h0c);
		vpp_wake();
		pins(7'h60);
		wr(`PMC_OFS_CMD, 32'h2);
		ext_sf  <= 1'b0;
		ext_int <= 1'b1;
		repeat (2) @(posedge pclk);
		ext_int <= 1'b0;
		repeat (6) @(posedge pclk);
		rd(`PMC_OFS_STATUS, 32'h3, 32'h7);
		ext_sf <= 1'b1;
		vpp_wake();
		wr(`PMC_OFS_PEND, 32'h1);
		// Enabled then masked external wake
		for (k = 1; k >= 0; k--)
		begin
			wr(`PMC_OFS_ENABLE, 32'(k));
			wr(`PMC_OFS_CMD, 32'h2);
			s = svc_cnt;
			ext_int <= 1'b1;
			repeat (2) @(posedge pclk);
			ext_int <= 1'b0;
			repeat (4) @(posedge pclk);
			rd(`PMC_OFS_STATUS, 32'h8a, 32'h8f);
			cmp("vpp_pulldown", 32'h1, {31'h0, pin_ctrl.vpp_pulldown});
			wait_on(0, 40);
			repeat (3) @(posedge pclk);
			cmp("service_count", 32'(k), 32'(svc_cnt - s));
			rd(`PMC_OFS_PEND, 32'h1, 32'h1);
			wr(`PMC_OFS_PEND, 32'h1);
			rd(`PMC_OFS_PEND, 32'h0, 32'h1);
		end
		wr(`PMC_OFS_CMD, 32'(3 + $urandom % 253));
		wait_on(1, 5);
		repeat (20) @(posedge pclk);
		cmp("reset_len", 32'd16, 32'(rst_len));
		wr(`PMC_OFS_CMD, 32'h2);
		{test_in, test_n} <= 2'h3;
		do_reset(16);
		cmp("modes", 32'h0, {30'h0, iso_mode, test_mode});
		rd(`PMC_OFS_STATUS, 32'h0, 32'h7);
		wr(`PMC_OFS_CFG0, 32'h1);
		wr(`PMC_OFS_ENABLE, 32'h2);
		wr(`PMC_OFS_WDOG, 32'h1e);
		wr(`PMC_OFS_WDOG, 32'he1);
		wr(`PMC_OFS_CMD, 32'h2);
		repeat (100) @(posedge pclk);
		cmp("reset_req", 32'h0, {31'h0, reset_req});
		vpp_wake();
		wr(`PMC_OFS_CMD, 32'h1);
		wait_on(1, 80);
		close_out;
	end
endmodule : power_mode_controller_bench
